// >>> common/ssc_map.vh
/*
 Register map for the sequencer step configuration bank of multiplexed converter A.
 Assumes a plain address/strobe register port with 8-bit word addresses.
*/
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

// Register addresses (word addresses on the register port)
`define SSC_ADDR_STEP_TEN    8'h9A
`define SSC_ADDR_STEP_ELEVEN 8'h9B

// Reset values
`define SSC_RST_STEP_TEN     16'h000A
`define SSC_RST_STEP_ELEVEN  16'h000B

// Field positions
`define SSC_BIT_ENABLE       15
`define SSC_GAIN_HI          14
`define SSC_GAIN_LO          13
`define SSC_RSV_HI           12
`define SSC_RSV_LO           5
`define SSC_BIT_NEG          4
`define SSC_POS_HI           3
`define SSC_POS_LO           0

// Writable bit mask: reserved field stays zero
`define SSC_WRITE_MASK       16'hE01F

// Positive-input codes
`define SSC_POS_LAST_EXT     4'h7
`define SSC_POS_TEMP         4'h8
`define SSC_POS_SHORT        4'h9
`define SSC_POS_DIG_PWR      4'hF

// Gain factor encodings on the decoded output
`define SSC_GAIN_X1          3'h1
`define SSC_GAIN_X2          3'h2
`define SSC_GAIN_X4          3'h4

`endif

// >>> core/ssc_step_config_bank.v
/*
 Step configuration register bank for the sequencer of multiplexed converter A,
 holding steps ten and eleven, with decoded settings for the sequencer engine.
 Assumes a single 100 MHz clock, synchronous active-high reset, and a register
 port master on the same clock that issues one-cycle strobes.
*/
// Summary of operation
// - Bit 15 enables sequence step ten when set and disables it when clear.
// - Gain bits 14:13 give gain 1 for 00, 2 for 01 and 4 for 10 or 11.
// - Bits 12:5 are reserved, read-only and always read as zero.
// - Bit 4 picks the negative input: 0 is converter ground, 1 is external input seven.
// - Positive codes 0000 to 0111 route external inputs zero to seven.
// - Positive codes 1000 and above select internal sources such as the temperature sensor.
// - For internal sources the negative select bit is ignored and chosen automatically.
// - Step ten register sits at 9Ah and resets to 000Ah.
// - Step eleven register sits at 9Bh and resets to 000Bh.
// - Step eleven uses the same field layout as step ten.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.vh"

module ssc_step_config_bank
(
	// Clock and reset
	input  wire        CLK_SYS_I,
	input  wire        RESET_I,
	// Register port
	input  wire [7:0]  REG_ADDR_I,
	input  wire [15:0] REG_WDATA_I,
	input  wire        REG_WR_I,
	input  wire        REG_RD_I,
	output wire [15:0] REG_RDATA_O,
	output wire        REG_ERR_O,
	// Step ten decoded settings
	output wire        STEP_TEN_ACTIVE_O,
	output wire [2:0]  STEP_TEN_GAIN_O,
	output wire [3:0]  STEP_TEN_POS_SEL_O,
	output wire        STEP_TEN_POS_INTERNAL_O,
	output wire        STEP_TEN_NEG_AUTO_O,
	output wire        STEP_TEN_NEG_EXT_SEVEN_O,
	// Step eleven decoded settings
	output wire        STEP_ELEVEN_ACTIVE_O,
	output wire [2:0]  STEP_ELEVEN_GAIN_O,
	output wire [3:0]  STEP_ELEVEN_POS_SEL_O,
	output wire        STEP_ELEVEN_POS_INTERNAL_O,
	output wire        STEP_ELEVEN_NEG_AUTO_O,
	output wire        STEP_ELEVEN_NEG_EXT_SEVEN_O
);

	reg  [15:0] step_ten_config_reg;
	reg  [15:0] step_eleven_config_reg;
	reg  [15:0] rdata_reg;
	reg  [15:0] rdata_next;
	reg         err_reg;
	wire        hit_ten;
	wire        hit_eleven;

	// Address decode
	assign hit_ten    = (REG_ADDR_I == `SSC_ADDR_STEP_TEN);
	assign hit_eleven = (REG_ADDR_I == `SSC_ADDR_STEP_ELEVEN);

	// Configuration storage; reserved bits are masked off on write
	always @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
		begin
			step_ten_config_reg    <= `SSC_RST_STEP_TEN;
			step_eleven_config_reg <= `SSC_RST_STEP_ELEVEN;
		end
		else if (REG_WR_I)
		begin
			if (hit_ten)
				step_ten_config_reg <= REG_WDATA_I & `SSC_WRITE_MASK;
			if (hit_eleven)
				step_eleven_config_reg <= REG_WDATA_I & `SSC_WRITE_MASK;
		end
	end

	// Read mux; unmapped addresses read zero
	always @*
	begin
		rdata_next = 16'h0000;
		if (hit_ten)
			rdata_next = step_ten_config_reg & `SSC_WRITE_MASK;
		else if (hit_eleven)
			rdata_next = step_eleven_config_reg & `SSC_WRITE_MASK;
	end

	// Read data and unmapped-access flag stand only in the cycle after the strobe
	always @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
		begin
			rdata_reg <= 16'h0000;
			err_reg   <= 1'b0;
		end
		else
		begin
			rdata_reg <= REG_RD_I ? rdata_next : 16'h0000;
			err_reg   <= (REG_RD_I | REG_WR_I) & ~(hit_ten | hit_eleven);
		end
	end

	assign REG_RDATA_O = rdata_reg;
	assign REG_ERR_O   = err_reg;

	// Step ten settings toward the sequencer
	ssc_step_decode u_step_ten
	(
		.cfg_i           (step_ten_config_reg),
		.active_o        (STEP_TEN_ACTIVE_O),
		.gain_factor_o   (STEP_TEN_GAIN_O),
		.pos_select_o    (STEP_TEN_POS_SEL_O),
		.pos_internal_o  (STEP_TEN_POS_INTERNAL_O),
		.neg_auto_o      (STEP_TEN_NEG_AUTO_O),
		.neg_ext_seven_o (STEP_TEN_NEG_EXT_SEVEN_O)
	);

	// Step eleven settings, same layout
	ssc_step_decode u_step_eleven
	(
		.cfg_i           (step_eleven_config_reg),
		.active_o        (STEP_ELEVEN_ACTIVE_O),
		.gain_factor_o   (STEP_ELEVEN_GAIN_O),
		.pos_select_o    (STEP_ELEVEN_POS_SEL_O),
		.pos_internal_o  (STEP_ELEVEN_POS_INTERNAL_O),
		.neg_auto_o      (STEP_ELEVEN_NEG_AUTO_O),
		.neg_ext_seven_o (STEP_ELEVEN_NEG_EXT_SEVEN_O)
	);

endmodule // ssc_step_config_bank
`default_nettype wire

// >>> core/ssc_step_decode.v
/*
 Decoder for one sequencer step configuration word: enable, gain factor,
 positive and negative input routing. Purely combinational, driven by the
 register outputs of the bank on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.vh"

module ssc_step_decode
(
	// Stored configuration word
	input  wire [15:0] cfg_i,
	// Decoded step settings
	output wire        active_o,
	output reg  [2:0]  gain_factor_o,
	output wire [3:0]  pos_select_o,
	output wire        pos_internal_o,
	output wire        neg_auto_o,
	output wire        neg_ext_seven_o
);

	wire [3:0] pos_code;

	assign pos_code = cfg_i[`SSC_POS_HI:`SSC_POS_LO];

	// Step runs only while its enable bit is set
	assign active_o = cfg_i[`SSC_BIT_ENABLE];

	// Gain code map: 00 -> 1, 01 -> 2, 10 and 11 -> 4
	always @*
	begin
		case (cfg_i[`SSC_GAIN_HI:`SSC_GAIN_LO])
			2'h0:    gain_factor_o = `SSC_GAIN_X1;
			2'h1:    gain_factor_o = `SSC_GAIN_X2;
			default: gain_factor_o = `SSC_GAIN_X4;
		endcase
	end

	// Codes 0..7 are external inputs, 8 and above internal sources
	assign pos_select_o   = pos_code;
	assign pos_internal_o = (pos_code > `SSC_POS_LAST_EXT);

	// Internal sources pick their negative input themselves
	assign neg_auto_o      = pos_internal_o;
	assign neg_ext_seven_o = ~neg_auto_o & cfg_i[`SSC_BIT_NEG];

endmodule // ssc_step_decode
`default_nettype wire

// >>> tb/ssc_asserts.sv
/* Port checker for the step configuration bank.
 Assumes it is bound to the bank and shares its clock. */
`timescale 1ns/1ps
`default_nettype none
module ssc_asserts (
	input wire logic        CLK_SYS_I, RESET_I, REG_WR_I, REG_RD_I, REG_ERR_O,
	input wire logic [7:0]  REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I, REG_RDATA_O,
	input wire logic        STEP_TEN_ACTIVE_O, STEP_TEN_NEG_AUTO_O, STEP_TEN_NEG_EXT_SEVEN_O,
	input wire logic [2:0]  STEP_TEN_GAIN_O,
	input wire logic [3:0]  STEP_TEN_POS_SEL_O, STEP_ELEVEN_POS_SEL_O
);
default clocking @(posedge CLK_SYS_I); endclocking
default disable iff (RESET_I);
// Last write data and step ten write strobe
logic [15:0] wq;
wire w10 = REG_WR_I && REG_ADDR_I == 8'h9A;
always_ff @(posedge CLK_SYS_I) wq <= REG_WDATA_I;
a_enable_write: assert property (w10 |=> STEP_TEN_ACTIVE_O == wq[15])
	else $error("enable wrong");
a_gain_code: assert property (w10 |=> STEP_TEN_GAIN_O ==
	{wq[14], !wq[14] && wq[13], !wq[14] && !wq[13]}) else $error("gain wrong");
a_rsv_zero: assert property (REG_RD_I |=> REG_RDATA_O[12:5] == 8'h00)
	else $error("reserved not zero");
a_ext_inputs: assert property (w10 && !REG_WDATA_I[3] |=>
	{STEP_TEN_NEG_EXT_SEVEN_O, STEP_TEN_POS_SEL_O} == wq[4:0]) else $error("input wrong");
a_auto_neg: assert property (STEP_TEN_NEG_AUTO_O == STEP_TEN_POS_SEL_O[3])
	else $error("auto negative wrong");
a_neg_ignored: assert property (STEP_TEN_NEG_AUTO_O |-> !STEP_TEN_NEG_EXT_SEVEN_O)
	else $error("negative select used");
a_read_enable: assert property (REG_RD_I && REG_ADDR_I == 8'h9A |=>
	REG_RDATA_O[15] == STEP_TEN_ACTIVE_O) else $error("readback wrong");
a_unmapped_err: assert property ((REG_WR_I || REG_RD_I) && REG_ADDR_I[7:1] != 7'h4D
	|=> REG_ERR_O) else $error("no error pulse");
a_eleven_pos: assert property (REG_WR_I && REG_ADDR_I == 8'h9B |=>
	STEP_ELEVEN_POS_SEL_O == wq[3:0]) else $error("step eleven wrong");
endmodule // ssc_asserts
bind ssc_step_config_bank ssc_asserts u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
	.REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ERR_O(REG_ERR_O), .REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
	.STEP_TEN_ACTIVE_O(STEP_TEN_ACTIVE_O), .STEP_TEN_NEG_AUTO_O(STEP_TEN_NEG_AUTO_O),
	.STEP_TEN_NEG_EXT_SEVEN_O(STEP_TEN_NEG_EXT_SEVEN_O), .STEP_TEN_GAIN_O(STEP_TEN_GAIN_O),
	.STEP_TEN_POS_SEL_O(STEP_TEN_POS_SEL_O), .STEP_ELEVEN_POS_SEL_O(STEP_ELEVEN_POS_SEL_O));
`default_nettype wire

// >>> tb/test_adc_sequence_step_config.sv
/* Self-checking bench for the step configuration bank.
 Assumes the bank and its checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequence_step_config;
logic clk = 0, rst = 1, wr = 0, rd = 0, err, a10, i10, n10, a11, i11, n11, u10, u11;
logic [7:0] a = 8'h00;
logic [15:0] wd = 16'h0000, rdat, d;
logic [2:0] g10, g11;
logic [3:0] p10, p11;
int n_fail = 0, n_tests = 0;
wire [10:0] v10 = {u10, a10, g10, i10, n10, p10};
wire [10:0] v11 = {u11, a11, g11, i11, n11, p11};
always #5 clk = ~clk;
ssc_step_config_bank i_dut (.CLK_SYS_I(clk), .RESET_I(rst), .REG_ADDR_I(a), .REG_WDATA_I(wd),
	.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .REG_ERR_O(err),
	.STEP_TEN_ACTIVE_O(a10), .STEP_TEN_GAIN_O(g10), .STEP_TEN_POS_SEL_O(p10),
	.STEP_TEN_POS_INTERNAL_O(i10), .STEP_TEN_NEG_AUTO_O(u10), .STEP_TEN_NEG_EXT_SEVEN_O(n10),
	.STEP_ELEVEN_ACTIVE_O(a11), .STEP_ELEVEN_GAIN_O(g11), .STEP_ELEVEN_POS_SEL_O(p11),
	.STEP_ELEVEN_POS_INTERNAL_O(i11), .STEP_ELEVEN_NEG_AUTO_O(u11),
	.STEP_ELEVEN_NEG_EXT_SEVEN_O(n11));
// Expected decoded settings of one configuration word
function logic [10:0] dec(input logic [15:0] v);
	dec = {v[3], v[15], v[14] ? 3'h4 : v[13] ? 3'h2 : 3'h1, v[3], v[4] & ~v[3], v[3:0]};
endfunction
task chk(input string s, input logic [15:0] x, input logic [15:0] y);
	n_tests++;
	if (x !== y)
	begin
		n_fail++;
		$display("[FAIL] %s exp %h got %h", s, x, y);
	end
endtask
// One-cycle write, returns just after the sampling edge
task wrt(input logic [7:0] ad, input logic [15:0] dv);
	@(posedge clk);
	wr <= 1;
	a <= ad;
	wd <= dv;
	@(posedge clk);
	wr <= 0;
	#1;
endtask
// One-cycle read, data checked in the following cycle
task rdc(input logic [7:0] ad, input logic [15:0] x);
	@(posedge clk);
	rd <= 1;
	a <= ad;
	@(posedge clk);
	rd <= 0;
	#1 chk("rdata", x, rdat);
endtask
task summarize;
	if (n_fail == 0 && n_tests > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
// Reset, reset values, all field codes on both steps, unmapped accesses
initial
begin
	repeat (20) @(posedge clk);
	rst <= 0;
	#1 chk("dec10", {5'h0, dec(16'h000A)}, {5'h0, v10});
	chk("dec11", {5'h0, dec(16'h000B)}, {5'h0, v11});
	rdc(8'h9A, 16'h000A);
	rdc(8'h9B, 16'h000B);
	for (int i = 0; i < 64; i++)
	begin
		d = {i[0], i[2:1], 8'hFF, i[4], i[3:0]};
		wrt({7'h4D, i[5]}, d);
		chk("decode", {5'h0, dec(d)}, {5'h0, i[5] ? v11 : v10});
		chk("err_mapped", 16'h0000, {15'h0, err});
		rdc({7'h4D, i[5]}, d & 16'hE01F);
	end
	wrt(8'h9C, 16'hFFFF);
	chk("err", 16'h0001, {15'h0, err});
	rdc(8'h9C, 16'h0000);
	rdc(8'h9B, d & 16'hE01F);
	summarize;
end
// Watchdog well beyond the expected run
initial
begin
	#100000;
	n_fail++;
	summarize;
end
endmodule // test_adc_sequence_step_config
`default_nettype wire
